// ---- verilog/nco_pkg.sv ----
// package of constants and register offsets for the oscillator core
package nco_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] NCO_OFF_CTRL = 8'h00; // enable, pin enable, out, polarity, mode
   localparam logic [7:0] NCO_OFF_CLK = 8'h04; // input_clock_control: pulse width, clock select
   localparam logic [7:0] NCO_OFF_INCL = 8'h08; // increment_low_byte
   localparam logic [7:0] NCO_OFF_INCH = 8'h0C; // increment_high_byte
   localparam logic [7:0] NCO_OFF_ACCL = 8'h10; // accumulator_low_byte
   localparam logic [7:0] NCO_OFF_ACCH = 8'h14; // accumulator_high_byte
   localparam logic [7:0] NCO_OFF_ACCU = 8'h18; // accumulator_upper_byte
   localparam logic [7:0] NCO_OFF_STAT = 8'h1C; // sticky event status, write one to clear
   localparam logic [7:0] NCO_OFF_MASK = 8'h20; // interrupt mask
   // control register fields
   localparam int NCO_CTRL_EN = 7;
   localparam int NCO_CTRL_OE = 6;
   localparam int NCO_CTRL_OUT = 5;
   localparam int NCO_CTRL_POL = 4;
   localparam int NCO_CTRL_PFM = 0;
   // clock register fields
   localparam int NCO_CLK_PWS_LSB = 5;
   localparam int NCO_CLK_CKS_LSB = 0;
   // reset values: everything clears to zero
   localparam logic [7:0] NCO_RST_BYTE = 8'h00;
   localparam logic [19:0] NCO_RST_ACC = 20'h00000;
   // clock source codes of the input_clock_select field
   localparam logic [1:0] NCO_CKS_FAST = 2'h0; // fast_internal_oscillator
   localparam logic [1:0] NCO_CKS_SYS = 2'h1; // system oscillator clock
   localparam logic [1:0] NCO_CKS_LC1 = 2'h2; // logic_cell1_output
   localparam logic [1:0] NCO_CKS_PIN = 2'h3; // external_clock_pin
   // input clock edges from a low-increment write to the buffer load
   localparam logic [1:0] NCO_LOAD_EDGES = 2'h2;
   // axi response codes
   localparam logic [1:0] NCO_RESP_OKAY = 2'h0;
   localparam logic [1:0] NCO_RESP_SLVERR = 2'h2;
endpackage : nco_pkg

// ---- verilog/nco_core.sv ----
// numerically controlled oscillator core with axi4-lite registers
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module nco_core
   import nco_pkg::*;
#(
   parameter int ACC_W = 20, // accumulator width
   parameter int INC_W = 16 // increment width
) (
   input wire logic aclk, // system clock, 10 mhz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic fast_internal_oscillator, // clock source 0
   input wire logic sys_osc_clock, // clock source 1
   input wire logic logic_cell1_output, // clock source 2
   input wire logic external_clock_pin, // clock source 3
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic nco_output, // shaped output to internal peripherals
   output logic nco_pin_out, // output pin level
   output logic nco_pin_oe, // output pin enable
   output logic irq // level interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   // input clock selection and synchronisation

   logic [3:0] src_sync1_ff; // first stage, read only by second
   logic [3:0] src_sync2_ff; // second stage
   logic sel_prev_ff; // previous selected clock level
   logic [7:0] ctrl_ff; // control register
   logic [7:0] clkc_ff; // input_clock_control register
   wire logic [1:0] input_clock_select = clkc_ff[NCO_CLK_CKS_LSB +: 2];
   wire logic [2:0] pulse_width_sel = clkc_ff[NCO_CLK_PWS_LSB +: 3];
   wire logic enabled = ctrl_ff[NCO_CTRL_EN];
   wire logic selected_input_clock = src_sync2_ff[input_clock_select];
   wire logic tick = enabled & selected_input_clock & ~sel_prev_ff;

   // sources come from outside this domain, so two flops each; edges are
   // detected on the sampled level, so input clocks must stay below aclk/2
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_sync1_ff <= 4'h0;
         src_sync2_ff <= 4'h0;
         sel_prev_ff <= 1'b0;
      end else begin
         src_sync1_ff <= {external_clock_pin, logic_cell1_output, sys_osc_clock,
                          fast_internal_oscillator};
         src_sync2_ff <= src_sync1_ff;
         sel_prev_ff <= selected_input_clock;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel

   logic [7:0] aw_addr_ff; // captured write address
   logic aw_held_ff; // write address captured
   logic [31:0] w_data_ff; // captured write data
   logic [3:0] w_strb_ff; // captured write strobes
   logic w_held_ff; // write data captured
   logic bvalid_ff; // write response pending
   logic [1:0] bresp_ff; // write response code
   assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   wire logic wr_go = aw_held_ff & w_held_ff & ~bvalid_ff; // both halves in
   wire logic wr_b0 = wr_go & w_strb_ff[0]; // only low lane carries data
   wire logic [7:0] wr_byte = w_data_ff[7:0];
   wire logic wr_hit = (aw_addr_ff <= NCO_OFF_MASK) & (aw_addr_ff[1:0] == 2'h0);
   wire logic wr_ctrl = wr_b0 & (aw_addr_ff == NCO_OFF_CTRL);
   wire logic wr_clk = wr_b0 & (aw_addr_ff == NCO_OFF_CLK);
   wire logic wr_incl = wr_b0 & (aw_addr_ff == NCO_OFF_INCL);
   wire logic wr_inch = wr_b0 & (aw_addr_ff == NCO_OFF_INCH);
   wire logic wr_accl = wr_b0 & (aw_addr_ff == NCO_OFF_ACCL);
   wire logic wr_acch = wr_b0 & (aw_addr_ff == NCO_OFF_ACCH);
   wire logic wr_accu = wr_b0 & (aw_addr_ff == NCO_OFF_ACCU);
   wire logic wr_stat = wr_b0 & (aw_addr_ff == NCO_OFF_STAT);
   wire logic wr_mask = wr_b0 & (aw_addr_ff == NCO_OFF_MASK);

   // address and data taken in either order; response once both are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= NCO_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? NCO_RESP_OKAY : NCO_RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control, increment and double buffer

   logic [7:0] incl_ff; // increment_low_byte, visible
   logic [7:0] inch_ff; // increment_high_byte, visible
   logic [INC_W-1:0] inc_buf_ff; // hidden increment buffer
   logic load_pend_ff; // low byte written while enabled
   logic [1:0] load_cnt_ff; // input clock edges seen since that write
   logic [7:0] mask_ff; // interrupt mask register
   wire logic load_now = load_pend_ff & tick & (load_cnt_ff == NCO_LOAD_EDGES - 2'h1);
   wire logic [INC_W-1:0] inc_new = {inch_ff, incl_ff};

   // registers written by software, all cleared by reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= NCO_RST_BYTE;
         clkc_ff <= NCO_RST_BYTE;
         incl_ff <= NCO_RST_BYTE;
         inch_ff <= NCO_RST_BYTE;
         mask_ff <= NCO_RST_BYTE;
      end else begin
         if (wr_ctrl) ctrl_ff <= wr_byte & 8'hD1; // out bit and gaps not stored; gaps read zero, out reads the live output
         if (wr_clk) clkc_ff <= wr_byte & 8'hE3;
         if (wr_incl) incl_ff <= wr_byte;
         if (wr_inch) inch_ff <= wr_byte;
         if (wr_mask) mask_ff <= wr_byte & 8'h01;
      end
   end

   // hidden buffer: immediate while disabled, second input edge while enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inc_buf_ff <= 16'h0000;
         load_pend_ff <= 1'b0;
         load_cnt_ff <= 2'h0;
      end else if (!enabled) begin
         inc_buf_ff <= inc_new;
         load_pend_ff <= 1'b0;
         load_cnt_ff <= 2'h0;
      end else if (wr_incl) begin
         load_pend_ff <= 1'b1; // a fresh write restarts the count
         load_cnt_ff <= 2'h0;
      end else if (load_now) begin
         inc_buf_ff <= inc_new; // (both halves together)
         load_pend_ff <= 1'b0;
         load_cnt_ff <= 2'h0;
      end else if (load_pend_ff && tick) begin
         load_cnt_ff <= load_cnt_ff + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator and adder

   logic [ACC_W-1:0] acc_ff; // accumulator
   wire logic [ACC_W:0] sum = {1'b0, acc_ff} + {{(ACC_W-INC_W+1){1'b0}}, inc_buf_ff};
   wire logic accumulator_carry = tick & sum[ACC_W];

   // software byte writes take priority over an add in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_ff <= NCO_RST_ACC;
      end else if (wr_accl) begin
         acc_ff[7:0] <= wr_byte;
      end else if (wr_acch) begin
         acc_ff[15:8] <= wr_byte;
      end else if (wr_accu) begin
         acc_ff[19:16] <= wr_byte[3:0];
      end else if (tick) begin
         acc_ff <= sum[ACC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output shaping, polarity and pin

   logic toggle_ff; // fixed_duty_mode flip-flop
   logic pulse_ff; // pulse_output_mode active
   logic [7:0] pulse_cnt_ff; // input periods left in the pulse
   logic out_q_ff; // registered shaped output
   wire logic pulse_mode_select = ctrl_ff[NCO_CTRL_PFM];
   wire logic [7:0] pulse_len = 8'h01 << pulse_width_sel; // 1..128 periods
   wire logic shaped = pulse_mode_select ? pulse_ff : toggle_ff;
   wire logic nxt_out = shaped ^ ctrl_ff[NCO_CTRL_POL];

   // pulse starts on the edge right after the carry; longer widths than the
   // overflow period give undefined output, so a new carry simply restarts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toggle_ff <= 1'b0;
         pulse_ff <= 1'b0;
         pulse_cnt_ff <= 8'h00;
         out_q_ff <= 1'b0;
      end else begin
         if (accumulator_carry) toggle_ff <= ~toggle_ff;
         if (accumulator_carry) begin
            pulse_ff <= 1'b1;
            pulse_cnt_ff <= pulse_len;
         end else if (tick && pulse_ff) begin
            pulse_cnt_ff <= pulse_cnt_ff - 8'h01;
            if (pulse_cnt_ff == 8'h01) pulse_ff <= 1'b0;
         end
         out_q_ff <= nxt_out;
      end
   end
   assign nco_output = out_q_ff;
   assign nco_pin_out = out_q_ff;
   assign nco_pin_oe = ctrl_ff[NCO_CTRL_OE];

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status

   logic stat_ff; // sticky overflow_event
   wire logic overflow_event = accumulator_carry;
   // a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) stat_ff <= 1'b0;
      else if (overflow_event) stat_ff <= 1'b1;
      else if (wr_stat && wr_byte[0]) stat_ff <= 1'b0;
   end
   assign irq = stat_ff & mask_ff[0];

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   logic rvalid_ff; // read data valid
   logic [31:0] rdata_ff; // read data
   logic [1:0] rresp_ff; // read response
   wire logic [7:0] rd_ctrl = {ctrl_ff[7:6], out_q_ff, ctrl_ff[4:0]};
   wire logic rd_hit = (s_axi_araddr <= NCO_OFF_MASK) & (s_axi_araddr[1:0] == 2'h0);
   wire logic [7:0] rd_byte =
      (s_axi_araddr == NCO_OFF_CTRL) ? rd_ctrl :
      (s_axi_araddr == NCO_OFF_CLK) ? clkc_ff :
      (s_axi_araddr == NCO_OFF_INCL) ? incl_ff :
      (s_axi_araddr == NCO_OFF_INCH) ? inch_ff :
      (s_axi_araddr == NCO_OFF_ACCL) ? acc_ff[7:0] :
      (s_axi_araddr == NCO_OFF_ACCH) ? acc_ff[15:8] :
      (s_axi_araddr == NCO_OFF_ACCU) ? {4'h0, acc_ff[19:16]} :
      (s_axi_araddr == NCO_OFF_STAT) ? {7'h00, stat_ff} :
      (s_axi_araddr == NCO_OFF_MASK) ? mask_ff : 8'h00;
   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // one read in flight; data registered the edge after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= NCO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= {24'h000000, rd_byte};
         rresp_ff <= rd_hit ? NCO_RESP_OKAY : NCO_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   chk_carry_steps_acc: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && !wr_accl && !wr_acch && !wr_accu) |=> acc_ff == $past(sum[ACC_W-1:0]))
      else $error("accumulator did not take the sum");
   chk_event_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      accumulator_carry |=> stat_ff) else $error("overflow did not set status");
   chk_toggle_on_carry: assert property (@(posedge aclk) disable iff (!aresetn)
      accumulator_carry |=> toggle_ff != $past(toggle_ff)) else $error("no toggle");
   chk_pulse_starts: assert property (@(posedge aclk) disable iff (!aresetn)
      accumulator_carry |=> pulse_ff ##0 pulse_cnt_ff == $past(pulse_len))
      else $error("pulse did not start");
   chk_idle_buffer_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (!enabled && $past(!enabled)) |-> inc_buf_ff == $past(inc_new))
      else $error("buffer not loaded while disabled");
   sequence s_low_write_enabled;
      enabled && wr_incl;
   endsequence
   chk_enabled_holds_buf: assert property (@(posedge aclk) disable iff (!aresetn)
      s_low_write_enabled ##1 (enabled && !tick && !wr_incl) |=> $stable(inc_buf_ff))
      else $error("buffer loaded before input edge");
   // second input edge after a low-byte write: both halves land together
   sequence s_second_edge;
      enabled && load_pend_ff && tick && !wr_incl && (load_cnt_ff == NCO_LOAD_EDGES - 2'h1);
   endsequence
   chk_second_edge_load: assert property (@(posedge aclk) disable iff (!aresetn)
      s_second_edge |=> inc_buf_ff == $past(inc_new))
      else $error("buffer not loaded on second input edge");
   chk_idle_acc_still: assert property (@(posedge aclk) disable iff (!aresetn)
      (!tick && !wr_accl && !wr_acch && !wr_accu) |=> $stable(acc_ff))
      else $error("accumulator moved without input edge");
   chk_mode_output: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> out_q_ff == (($past(pulse_mode_select) ? $past(pulse_ff) : $past(toggle_ff))
                ^ $past(ctrl_ff[NCO_CTRL_POL]))) else $error("wrong output mode");
   chk_reset_clears: assert property (@(posedge aclk)
      !aresetn |=> acc_ff == NCO_RST_ACC && ctrl_ff == NCO_RST_BYTE)
      else $error("reset did not clear");

endmodule : nco_core
`default_nettype wire

// ---- tb/nco_src_model.sv ----
// clock-source and output-consumer model for the oscillator bench
`timescale 1ns/1ns
`default_nettype none
module nco_src_model (
   input wire logic aclk, // system clock
   input wire logic [1:0] src_sel, // source that carries the edges
   input wire logic nco_output, // shaped output from the core
   output logic [3:0] src_clk, // the four clock sources
   output int rises // rising edges seen by the consumer
);
   logic prev_out; // consumer's last sample
   initial begin
      src_clk = 4'h0;
      rises = 0;
      prev_out = 1'b0;
   end
   // k input periods; high and low >= 4 aclk so the synchroniser sees each
   // idle sources stand still low, as a stopped oscillator would
   task automatic emit(input int k);
      repeat (k) begin
         @(posedge aclk);
         src_clk[src_sel] <= 1'b1;
         repeat (4) @(posedge aclk);
         src_clk[src_sel] <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      // let the last edge cross the synchroniser before anyone looks
      repeat (6) @(posedge aclk);
   endtask : emit
   // consumer peripheral: counts rising edges of the shaped output
   always @(posedge aclk) begin
      prev_out <= nco_output;
      if (nco_output && !prev_out) begin
         rises <= rises + 1;
      end
   end
endmodule : nco_src_model
`default_nettype wire

// ---- tb/tb_numeric_oscillator_core.sv ----
// self-checking bench for the oscillator core
`timescale 1ns/1ns
`default_nettype none
module tb_numeric_oscillator_core;
   import nco_pkg::*;
   logic aclk, aresetn; // clock, reset
   logic [7:0] awaddr, araddr; // bus addresses
   logic [31:0] wdata, rdata; // bus data
   logic [3:0] wstrb; // write strobes
   logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
   logic awready, wready, bvalid, arready, rvalid; // slave handshakes
   logic [1:0] bresp, rresp, rresp_seen, bresp_seen; // responses
   logic nco_output, pin_out, pin_oe, irq; // core outputs
   logic [3:0] src_clk; // clock sources
   logic [1:0] src_sel; // selected source in the model
   int rises, miscompares, compares, cycles; // counters
   nco_core nco_core_inst (.aclk(aclk), .aresetn(aresetn),
      .fast_internal_oscillator(src_clk[0]), .sys_osc_clock(src_clk[1]),
      .logic_cell1_output(src_clk[2]), .external_clock_pin(src_clk[3]),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nco_output(nco_output),
      .nco_pin_out(pin_out), .nco_pin_oe(pin_oe), .irq(irq));
   nco_src_model nco_src_model_inst (.aclk(aclk), .src_sel(src_sel),
      .nco_output(nco_output), .src_clk(src_clk), .rises(rises));
   ////////////////////////////////////////////////////////////////
   // clock and watchdog; the run needs about eleven hundred cycles
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // bus write: both halves offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bresp_seen = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            rresp_seen = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(what, exp, d);
   endtask : rd_chk
   task set_acc(input logic [19:0] v);
      wr(NCO_OFF_ACCL, v[7:0]);
      wr(NCO_OFF_ACCH, v[15:8]);
      wr(NCO_OFF_ACCU, {4'h0, v[19:16]});
   endtask : set_acc
   // accumulator assembled from its three byte registers
   task chk_acc(input logic [19:0] exp);
      logic [31:0] l, h, u;
      rd(NCO_OFF_ACCL, l);
      rd(NCO_OFF_ACCH, h);
      rd(NCO_OFF_ACCU, u);
      chk("accumulator", {12'h000, exp}, {12'h000, u[3:0], h[7:0], l[7:0]});
   endtask : chk_acc
   ////////////////////////////////////////////////////////////////
   // every register reads zero out of reset
   task t_reset;
      for (int i = 0; i <= 8; i++) begin
         rd_chk("reset value", 8'(i * 4), 32'h00000000);
      end
   endtask : t_reset
   // increment bytes read back; an unmapped offset is refused
   task t_regs;
      wr(NCO_OFF_INCH, 8'hA5);
      wr(NCO_OFF_INCL, 8'h5A);
      chk("write resp", {30'h0, NCO_RESP_OKAY}, {30'h0, bresp_seen});
      rd_chk("inc high", NCO_OFF_INCH, 32'h000000A5);
      rd_chk("inc low", NCO_OFF_INCL, 32'h0000005A);
      chk("read resp", {30'h0, NCO_RESP_OKAY}, {30'h0, rresp_seen});
      rd_chk("unmapped data", 8'h24, 32'h00000000);
      chk("unmapped resp", {30'h0, NCO_RESP_SLVERR}, {30'h0, rresp_seen});
      wr(8'h24, 8'h11);
      chk("unmapped wr resp", {30'h0, NCO_RESP_SLVERR}, {30'h0, bresp_seen});
   endtask : t_regs
   // 17 adds of FFFF from zero on each source: one carry, remainder kept
   task t_sources;
      wr(NCO_OFF_INCH, 8'hFF);
      wr(NCO_OFF_INCL, 8'hFF);
      wr(NCO_OFF_CTRL, 8'h80);
      for (int s = 0; s < 4; s++) begin
         wr(NCO_OFF_CLK, {6'h00, 2'(s)});
         src_sel <= 2'(s);
         set_acc(20'h00000);
         nco_src_model_inst.emit(17);
         chk_acc(20'h0FFEF);
         chk("toggle out", {31'h0, ~s[0]}, {31'h0, nco_output});
         chk("pin off", 32'h0, {31'h0, pin_oe});
      end
      chk("consumer rises", 32'd2, 32'(rises));
   endtask : t_sources
   // overflow flag, mask and write-one-to-clear
   task t_interrupt;
      chk("irq masked", 32'h0, {31'h0, irq});
      rd_chk("status", NCO_OFF_STAT, 32'h00000001);
      wr(NCO_OFF_MASK, 8'h01);
      chk("irq on", 32'h1, {31'h0, irq});
      wr(NCO_OFF_STAT, 8'h01);
      chk("irq off", 32'h0, {31'h0, irq});
      rd_chk("status clr", NCO_OFF_STAT, 32'h00000000);
   endtask : t_interrupt
   // enabled: high byte alone changes nothing; low byte loads on 2nd edge
   task t_double_buffer;
      wr(NCO_OFF_CTRL, 8'h00);
      wr(NCO_OFF_INCH, 8'h00);
      wr(NCO_OFF_INCL, 8'h01);
      set_acc(20'h00000);
      wr(NCO_OFF_CTRL, 8'h80);
      wr(NCO_OFF_INCH, 8'h01);
      nco_src_model_inst.emit(2);
      chk_acc(20'h00002);
      wr(NCO_OFF_INCL, 8'h00);
      nco_src_model_inst.emit(4);
      chk_acc(20'h00204);
   endtask : t_double_buffer
   // pulse mode, width one input period, driven to the pin
   task t_pulse;
      wr(NCO_OFF_CTRL, 8'h00);
      wr(NCO_OFF_INCH, 8'h80);
      wr(NCO_OFF_INCL, 8'h00);
      set_acc(20'hF8000);
      wr(NCO_OFF_CLK, 8'h03);
      wr(NCO_OFF_CTRL, 8'hC1);
      nco_src_model_inst.emit(1);
      chk("pulse high", 32'h1, {31'h0, nco_output});
      chk("pin enable", 32'h1, {31'h0, pin_oe});
      chk("pin level", 32'h1, {31'h0, pin_out});
      nco_src_model_inst.emit(1);
      chk("pulse low", 32'h0, {31'h0, nco_output});
      // width two periods with inverted polarity: active low
      wr(NCO_OFF_CTRL, 8'h00);
      set_acc(20'hF8000);
      wr(NCO_OFF_CLK, 8'h23);
      wr(NCO_OFF_CTRL, 8'hD1);
      nco_src_model_inst.emit(1);
      chk("inverted pulse", 32'h0, {31'h0, nco_output});
      nco_src_model_inst.emit(1);
      chk("pulse width two", 32'h0, {31'h0, nco_output});
      nco_src_model_inst.emit(1);
      chk("inverted idle", 32'h1, {31'h0, nco_output});
      rd_chk("out bit", NCO_OFF_CTRL, 32'h000000F1);
   endtask : t_pulse
   // a reset in mid-run must clear state left by the earlier scenarios
   task t_reset_mid;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk("irq after reset", 32'h0, {31'h0, irq});
      chk("pin after reset", 32'h0, {31'h0, pin_oe});
      chk("out after reset", 32'h0, {31'h0, nco_output});
      t_reset();
   endtask : t_reset_mid
   ////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      src_sel = 2'h0;
      rresp_seen = 2'h0;
      bresp_seen = 2'h0;
      {miscompares, compares, cycles} = {32'd0, 32'd0, 32'd0};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_regs();
      t_sources();
      t_interrupt();
      t_double_buffer();
      t_pulse();
      t_reset_mid();
      end_of_test();
   end
endmodule : tb_numeric_oscillator_core
`default_nettype wire
